// file: logic/swh_defines.svh
`ifndef SWH_DEFINES_SVH
`define SWH_DEFINES_SVH

// ==========================================================
// register word addresses on the command port
`define SWH_A_CTRL 3'h0
`define SWH_A_STAT 3'h1
`define SWH_A_RX 3'h2
`define SWH_A_ADDR 3'h3
`define SWH_A_CFG 3'h4

// ==========================================================
// field positions
`define SWH_CFG_CRC_CLR 0
`define SWH_CFG_OD_CLR 1
`define SWH_CFG_REF_CLR 2
`define SWH_ST_CRC_OK 4
`define SWH_ST_OFFS 6

// ==========================================================
// identity-selection and memory command codes
`define SWH_CMD_READ_ID 8'h33
`define SWH_CMD_MATCH 8'h55
`define SWH_CMD_SEARCH 8'hF0
`define SWH_CMD_SKIP 8'hCC
`define SWH_CMD_OD_SKIP 8'h3C
`define SWH_CMD_OD_MATCH 8'h69
`define SWH_CMD_WR_SP 8'h0F
`define SWH_CMD_RD_SP 8'hAA
`define SWH_CMD_CP_SP 8'h5A
`define SWH_CMD_RD_MEM 8'hF0
`define SWH_CMD_RD_CNT 8'hA5

// ==========================================================
// check value: x8+x5+x4+1, reflected for lsb-first shifting
`define SWH_CRC_POLY 8'h8C
`define SWH_ID_ARG_BYTES 4'h8

// ==========================================================
// timing, figures in ns, clock 10 MHz
`define SWH_CLK_NS 100
`define SWH_CYC_MIN(ns) (((ns) + `SWH_CLK_NS - 1) / `SWH_CLK_NS)
`define SWH_STD_RST_LOW_NS 480000
`define SWH_STD_PRES_NS 70000
`define SWH_STD_RST_REC_NS 410000
`define SWH_STD_W1_NS 6000
`define SWH_STD_W0_NS 60000
`define SWH_STD_RDS_NS 15000
`define SWH_STD_SLOT_NS 70000
`define SWH_OD_RST_LOW_NS 70000
`define SWH_OD_PRES_NS 8500
`define SWH_OD_RST_REC_NS 40000
`define SWH_OD_W1_NS 1000
`define SWH_OD_W0_NS 7500
`define SWH_OD_RDS_NS 2000
`define SWH_OD_SLOT_NS 10000

`endif

// file: logic/swh_pkg.sv
`default_nettype none
package swh_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RST = 2'b01,
    ST_SLOT = 2'b10
  } swh_state_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RST = 2'b01,
    OP_WR = 2'b10,
    OP_RD = 2'b11
  } swh_op_e;

  typedef enum logic [1:0] {
    PH_ROM = 2'b00,
    PH_MEMCMD = 2'b01,
    PH_DATA = 2'b10
  } swh_phase_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } swh_bus_s;

  typedef struct packed {
    swh_state_e st;
    swh_op_e op;
    swh_phase_e phase;
    logic [12:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] crc;
    logic samp;
    logic presence;
    logic selected;
    logic od;
    logic od_arm;
    logic refused;
    logic [3:0] skip;
    logic [7:0] mem_cmd;
    logic [1:0] idx;
    logic [7:0] ta_lo;
    logic [7:0] ta_hi;
    logic [7:0] es;
    logic dq_meta;
    logic dq_sync;
    logic dq_oe;
    logic [31:0] rdata;
  } swh_regs_s;

endpackage
`default_nettype wire

// file: logic/swh_ctrl.sv
// How it works
// - check value uses shift register with XOR feedback, x8+x5+x4+1.
// - check register starts zero; family then serial shifted in, lsb first.
// - receiver shifts in check byte too; all-zero result means good code.
// - every byte on the line travels least significant bit first.
// - identity-selection command first; memory commands only after one succeeds; the controller refuses memory-only codes only as first byte after reset.
// - two target address registers hold write or read address, loaded first.
// - master should start writes at offset zero; partial contiguous writes allowed. The controller accepts any offset and only flags a nonzero one in status.
`include "swh_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module swh_ctrl #(
  parameter int T_RST_LOW_S = `SWH_CYC_MIN(`SWH_STD_RST_LOW_NS),
  parameter int T_PRES_S = `SWH_CYC_MIN(`SWH_STD_PRES_NS),
  parameter int T_RST_REC_S = `SWH_CYC_MIN(`SWH_STD_RST_REC_NS),
  parameter int T_W1_S = `SWH_CYC_MIN(`SWH_STD_W1_NS),
  parameter int T_W0_S = `SWH_CYC_MIN(`SWH_STD_W0_NS),
  parameter int T_RDS_S = `SWH_CYC_MIN(`SWH_STD_RDS_NS),
  parameter int T_SLOT_S = `SWH_CYC_MIN(`SWH_STD_SLOT_NS),
  parameter int T_RST_LOW_O = `SWH_CYC_MIN(`SWH_OD_RST_LOW_NS),
  parameter int T_PRES_O = `SWH_CYC_MIN(`SWH_OD_PRES_NS),
  parameter int T_RST_REC_O = `SWH_CYC_MIN(`SWH_OD_RST_REC_NS),
  parameter int T_W1_O = `SWH_CYC_MIN(`SWH_OD_W1_NS),
  parameter int T_W0_O = `SWH_CYC_MIN(`SWH_OD_W0_NS),
  parameter int T_RDS_O = `SWH_CYC_MIN(`SWH_OD_RDS_NS),
  parameter int T_SLOT_O = `SWH_CYC_MIN(`SWH_OD_SLOT_NS)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // command port
  input wire swh_pkg::swh_bus_s bus,
  output logic [31:0] rdata,
  output logic busy,
  // single data line, open drain
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe
);

  // ==========================================================
  // elaboration checks
  if (T_RST_LOW_S + T_RST_REC_S > 8191 || T_RST_LOW_O + T_RST_REC_O > 8191) begin : g_chk_rst
    $error("reset timing exceeds counter range");
  end
  if (T_W1_S < 1 || T_W1_S >= T_RDS_S || T_RDS_S >= T_SLOT_S || T_W0_S >= T_SLOT_S) begin : g_chk_s
    $error("standard slot timing inconsistent");
  end
  if (T_W1_O < 1 || T_W1_O >= T_RDS_O || T_RDS_O >= T_SLOT_O || T_W0_O >= T_SLOT_O) begin : g_chk_o
    $error("high speed slot timing inconsistent");
  end
  if (T_PRES_S >= T_RST_REC_S || T_PRES_O >= T_RST_REC_O || T_SLOT_S > 8191) begin : g_chk_p
    $error("presence sample outside recovery");
  end

  // ==========================================================
  // derived counts: reset low as its length, the others as last counter value of their phase
  localparam logic [12:0] C_RLOW_S = 13'(T_RST_LOW_S);
  localparam logic [12:0] C_PRES_S = 13'(T_RST_LOW_S + T_PRES_S - 1);
  localparam logic [12:0] C_REND_S = 13'(T_RST_LOW_S + T_RST_REC_S - 1);
  localparam logic [12:0] C_RLOW_O = 13'(T_RST_LOW_O);
  localparam logic [12:0] C_PRES_O = 13'(T_RST_LOW_O + T_PRES_O - 1);
  localparam logic [12:0] C_REND_O = 13'(T_RST_LOW_O + T_RST_REC_O - 1);

  swh_pkg::swh_regs_s q;
  swh_pkg::swh_regs_s d;

  logic [12:0] rst_low;
  logic [12:0] pres_at;
  logic [12:0] rst_end;
  logic [12:0] w1_len;
  logic [12:0] w0_len;
  logic [12:0] rds_at;
  logic [12:0] slot_end;
  logic [12:0] low_len;
  logic wr_ctrl;
  logic wr_cfg;
  logic [7:0] wd;
  swh_pkg::swh_op_e op_in;
  logic is_sel;
  logic is_od;
  logic mem_only;
  logic takes_ta;
  logic wr_acc;
  logic bit_done;
  logic byte_done;
  logic bitv;
  logic crc_fb;
  logic [7:0] status_b;

  // ==========================================================
  // speed selection and decode
  always_comb begin
    rst_low = q.od ? C_RLOW_O : C_RLOW_S;
    pres_at = q.od ? C_PRES_O : C_PRES_S;
    rst_end = q.od ? C_REND_O : C_REND_S;
    w1_len = q.od ? 13'(T_W1_O) : 13'(T_W1_S);
    w0_len = q.od ? 13'(T_W0_O) : 13'(T_W0_S);
    rds_at = q.od ? 13'(T_RDS_O - 1) : 13'(T_RDS_S - 1);
    slot_end = q.od ? 13'(T_SLOT_O - 1) : 13'(T_SLOT_S - 1);
    wr_ctrl = bus.wr && bus.addr == `SWH_A_CTRL;
    wr_cfg = bus.wr && bus.addr == `SWH_A_CFG;
    wd = bus.wdata[15:8];
    op_in = swh_pkg::swh_op_e'(bus.wdata[1:0]);
    is_sel = wd == `SWH_CMD_READ_ID || wd == `SWH_CMD_MATCH || wd == `SWH_CMD_SEARCH ||
             wd == `SWH_CMD_SKIP || wd == `SWH_CMD_OD_SKIP || wd == `SWH_CMD_OD_MATCH;
    is_od = wd == `SWH_CMD_OD_SKIP || wd == `SWH_CMD_OD_MATCH;
    // read memory shares its code with search, so it counts as selection here
    mem_only = wd == `SWH_CMD_WR_SP || wd == `SWH_CMD_RD_SP || wd == `SWH_CMD_CP_SP ||
               wd == `SWH_CMD_RD_CNT;
    takes_ta = q.mem_cmd == `SWH_CMD_WR_SP || q.mem_cmd == `SWH_CMD_RD_MEM ||
               q.mem_cmd == `SWH_CMD_RD_CNT;
    wr_acc = wr_ctrl && q.st == swh_pkg::ST_IDLE && op_in == swh_pkg::OP_WR &&
             !(q.phase == swh_pkg::PH_ROM && mem_only);
    bitv = q.op == swh_pkg::OP_RD ? q.samp : q.sh[0];
    crc_fb = q.crc[0] ^ bitv;
    // zero check register flags a good identity
    // flag a write start off a page boundary
    status_b = {1'b0, q.ta_lo[4:0] != 5'h00, q.refused, q.crc == 8'h00, q.od, q.selected,
                q.presence, q.st != swh_pkg::ST_IDLE};
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.dq_meta = dq_i;
    d.dq_sync = q.dq_meta;
    d.rdata = 32'h0000_0000;
    bit_done = 1'b0;
    byte_done = 1'b0;
    if (bus.rd) begin
      case (bus.addr)
        `SWH_A_CTRL, `SWH_A_STAT: d.rdata = {16'h0000, q.crc, status_b};
        `SWH_A_RX: d.rdata = {24'h00_0000, q.rx};
        // low address byte in the low lane
        `SWH_A_ADDR: d.rdata = {8'h00, q.es, q.ta_hi, q.ta_lo};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // clear first, so a refusal in the same cycle still sticks
    if (wr_cfg && bus.wdata[`SWH_CFG_REF_CLR]) begin
      d.refused = 1'b0;
    end
    if (wr_cfg && bus.wdata[`SWH_CFG_OD_CLR]) begin
      d.od = 1'b0;
    end
    unique case (q.st)
      swh_pkg::ST_IDLE: begin
        if (wr_ctrl) begin
          unique case (op_in)
            swh_pkg::OP_RST: begin
              d.st = swh_pkg::ST_RST;
              d.cnt = 13'h0000;
              d.phase = swh_pkg::PH_ROM;
              d.selected = 1'b0;
              d.presence = 1'b0;
              d.skip = 4'h0;
              d.od_arm = 1'b0;
            end
            swh_pkg::OP_WR: begin
              // memory-only command refused until some other byte is accepted after a reset
              if (!wr_acc) begin
                d.refused = 1'b1;
              end else begin
                d.st = swh_pkg::ST_SLOT;
                d.op = swh_pkg::OP_WR;
                // shifted out from bit 0 upward
                d.sh = wd;
                d.bit_idx = 3'h0;
                d.cnt = 13'h0000;
                unique case (q.phase)
                  swh_pkg::PH_ROM: begin
                    d.selected = is_sel;
                    d.phase = is_sel ? swh_pkg::PH_MEMCMD : swh_pkg::PH_DATA;
                    d.mem_cmd = 8'h00;
                    d.skip = (wd == `SWH_CMD_MATCH || wd == `SWH_CMD_OD_MATCH) ?
                             `SWH_ID_ARG_BYTES : 4'h0;
                    // only a standard-speed selection byte switches speed
                    d.od_arm = is_od && !q.od;
                  end
                  swh_pkg::PH_MEMCMD: begin
                    if (q.skip != 4'h0) begin
                      d.skip = q.skip - 4'h1;
                    end else begin
                      d.mem_cmd = wd;
                      d.phase = swh_pkg::PH_DATA;
                      d.idx = 2'h0;
                    end
                  end
                  swh_pkg::PH_DATA: begin
                    // target address sent low byte then high byte
                    if (takes_ta && q.idx == 2'h0) begin
                      d.ta_lo = wd;
                      d.idx = 2'h1;
                    end else if (takes_ta && q.idx == 2'h1) begin
                      d.ta_hi = wd;
                      d.idx = 2'h2;
                    end
                  end
                  default: d.phase = swh_pkg::PH_ROM;
                endcase
              end
            end
            swh_pkg::OP_RD: begin
              d.st = swh_pkg::ST_SLOT;
              d.op = swh_pkg::OP_RD;
              d.sh = 8'hFF;
              d.bit_idx = 3'h0;
              d.cnt = 13'h0000;
            end
            swh_pkg::OP_NONE: begin
            end
          endcase
        end
      end
      swh_pkg::ST_RST: begin
        d.cnt = q.cnt + 13'h0001;
        if (q.cnt == pres_at) begin
          d.presence = !q.dq_sync;
        end
        if (q.cnt == rst_end) begin
          d.st = swh_pkg::ST_IDLE;
        end
      end
      swh_pkg::ST_SLOT: begin
        d.cnt = q.cnt + 13'h0001;
        if (q.op == swh_pkg::OP_RD && q.cnt == rds_at) begin
          d.samp = q.dq_sync;
        end
        if (q.cnt == slot_end) begin
          bit_done = 1'b1;
          d.cnt = 13'h0000;
          // lsb-first shift with reflected feedback taps
          d.crc = {1'b0, q.crc[7:1]} ^ (crc_fb ? `SWH_CRC_POLY : 8'h00);
          // read bits fill from the top, so bit 0 arrives first
          d.sh = {bitv, q.sh[7:1]};
          d.bit_idx = q.bit_idx + 3'h1;
          if (q.bit_idx == 3'h7) begin
            byte_done = 1'b1;
            d.st = swh_pkg::ST_IDLE;
            if (q.od_arm) begin
              d.od = 1'b1;
              d.od_arm = 1'b0;
            end
            if (q.op == swh_pkg::OP_RD) begin
              d.rx = {bitv, q.sh[7:1]};
              // scratchpad read opens with address bytes and status
              if (q.phase == swh_pkg::PH_DATA && q.mem_cmd == `SWH_CMD_RD_SP && q.idx != 2'h3) begin
                d.idx = q.idx + 2'h1;
                if (q.idx == 2'h0) begin
                  d.ta_lo = {bitv, q.sh[7:1]};
                end else if (q.idx == 2'h1) begin
                  d.ta_hi = {bitv, q.sh[7:1]};
                end else begin
                  d.es = {bitv, q.sh[7:1]};
                end
              end
            end
          end
        end
      end
      default: d.st = swh_pkg::ST_IDLE;
    endcase
    // software zeroes the check register before an identity read
    if (wr_cfg && bus.wdata[`SWH_CFG_CRC_CLR]) begin
      d.crc = 8'h00;
    end
    low_len = (d.op == swh_pkg::OP_WR && !d.sh[0]) ? w0_len : w1_len;
    d.dq_oe = (d.st == swh_pkg::ST_RST && d.cnt < rst_low) ||
              (d.st == swh_pkg::ST_SLOT && d.cnt < low_len);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign busy = q.st != swh_pkg::ST_IDLE;
  assign dq_o = 1'b0;
  assign dq_oe = q.dq_oe;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_crc_shift;
    bit_done && !crc_fb && !(wr_cfg && bus.wdata[`SWH_CFG_CRC_CLR]) |=> q.crc == ($past(q.crc) >> 1);
  endproperty
  a_crc_shift: assert property (p_crc_shift) else $error("check register shift wrong");

  property p_crc_clear;
    wr_cfg && bus.wdata[`SWH_CFG_CRC_CLR] |=> q.crc == 8'h00;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("check register not cleared");

  property p_crc_ok;
    bus.rd && bus.addr == `SWH_A_STAT |=> rdata[`SWH_ST_CRC_OK] == ($past(q.crc) == 8'h00);
  endproperty
  a_crc_ok: assert property (p_crc_ok) else $error("check ok bit mismatch");

  property p_lsb_out;
    wr_acc |=> q.st == swh_pkg::ST_SLOT && q.sh == $past(wd) && q.dq_oe;
  endproperty
  a_lsb_out: assert property (p_lsb_out) else $error("write byte not started");

  property p_lsb_in;
    byte_done && q.op == swh_pkg::OP_RD |=> q.rx[7] == $past(bitv) && q.rx[6:0] == $past(q.sh[7:1]);
  endproperty
  a_lsb_in: assert property (p_lsb_in) else $error("read byte order wrong");

  property p_refuse;
    wr_ctrl && q.st == swh_pkg::ST_IDLE && op_in == swh_pkg::OP_WR && q.phase == swh_pkg::PH_ROM && mem_only
      |=> q.refused && q.st == swh_pkg::ST_IDLE ##1 !q.dq_oe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("memory command not refused");

  property p_od_switch;
    byte_done && q.od_arm |=> q.od && !q.od_arm;
  endproperty
  a_od_switch: assert property (p_od_switch) else $error("speed switch missed");

  property p_ta_load;
    wr_acc && q.phase == swh_pkg::PH_DATA && takes_ta && q.idx == 2'h0 |=> q.ta_lo == $past(wd) && q.idx == 2'h1;
  endproperty
  a_ta_load: assert property (p_ta_load) else $error("target address not loaded");

  property p_offs;
    bus.rd && bus.addr == `SWH_A_STAT |=> rdata[`SWH_ST_OFFS] == ($past(q.ta_lo[4:0]) != 5'h00);
  endproperty
  a_offs: assert property (p_offs) else $error("page offset flag wrong");

  c_presence: cover property (q.st == swh_pkg::ST_RST ##1 $rose(q.presence));
  c_od: cover property ($rose(q.od));
  c_refused: cover property ($rose(q.refused));
  c_es_cap: cover property (byte_done && q.idx == 2'h2 && q.mem_cmd == `SWH_CMD_RD_SP);

endmodule

`default_nettype wire

// file: sim/swh_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// behavioural device on the far side of the data line
module swh_dev_model #(
  // arbitrary identity values
  parameter logic [7:0] FAMILY = 8'h6B,
  parameter logic [47:0] SERIAL = 48'h00C0FFEE1234
) (
  // clock and line
  input wire logic clk,
  input wire logic line,
  output logic pull,
  // counter trigger pins, active low
  input wire logic [1:0] trig_n
);
  logic [63:0] id;
  logic [23:0] auth;
  logic [7:0] ta_lo = 8'h00, ta_hi = 8'h00, es = 8'h00, rxb = 8'h00, cmd = 8'h00;
  logic [5:0] lowc = 6'h00;
  logic [3:0] hold = 4'h0;
  logic prev = 1'b1, skip = 1'b0, od = 1'b0, ok = 1'b0;
  int rxn = 0, txn = 0, nb = 0, st = 0;
  logic [7:0] txq[$];
  // counters start at zero and have no write path
  logic [31:0] wcnt[2] = '{32'h0, 32'h0};
  logic [31:0] tcnt[2] = '{32'h0, 32'h0};
  logic [2:0] tdb[2] = '{3'h7, 3'h7};
  logic [1:0] tlvl = 2'b11;
  function automatic logic [7:0] crc8(input logic [55:0] dat);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ dat[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction
  assign id = {crc8({SERIAL, FAMILY}), SERIAL, FAMILY};
  assign auth = {es, ta_hi, ta_lo};
  assign pull = hold != 4'h0;
  task automatic take(input logic [7:0] b);
    case (st)
      0: begin
        od = od | (b == 8'h3C) | (b == 8'h69);
        st = 1;
        ok = 1'b1;
        nb = 0;
        case (b)
          8'h33: for (int i = 0; i < 8; i++) txq.push_back(id[8*i +: 8]);
          8'h55, 8'h69: st = 2;
          8'hCC, 8'h3C: st = 1;
          default: st = 7;
        endcase
      end
      2: begin
        ok &= b == id[8*nb +: 8];
        nb++;
        if (nb == 8) st = ok ? 1 : 7;
      end
      1: begin
        // memory commands only after a selection
        cmd = b;
        st = (b == 8'h0F || b == 8'hF0 || b == 8'hA5) ? 3 : (b == 8'h5A) ? 6 : 7;
        if (b == 8'hAA) txq = '{ta_lo, ta_hi, es};
      end
      3: begin
        ta_lo = b;
        st = 4;
      end
      4: begin
        ta_hi = b;
        st = (cmd == 8'h0F) ? 5 : 7;
        nb = ta_lo[4:0];
      end
      5: begin
        // ending offset, copy flag cleared, full at 1FH
        es = {3'b000, nb[4:0]};
        nb++;
        if (nb == 32) st = 7;
      end
      6: begin
        ok &= b == auth[8*nb +: 8];
        nb++;
        if (nb == 3 && ok) es[7] = 1'b1;
        // pages 12 and 13 count their copies
        if (nb == 3 && ok && ta_hi[0] && ta_lo[7:6] == 2'b10) wcnt[ta_lo[5]] = wcnt[ta_lo[5]] + 32'h1;
        if (nb == 3) st = 7;
      end
      default: st = 7;
    endcase
  endtask
  always @(posedge clk) begin
    if (hold != 4'h0) hold <= hold - 4'h1;
    if (!line) lowc = lowc + 6'h01;
    if (line && !prev) begin
      if (lowc >= 6'h0F) begin
        // byte cut short by a reset
        if (st == 5 && rxn != 0) es[5] = 1'b1;
        st = 0;
        rxn = 0;
        txn = 0;
        txq.delete();
        hold <= 4'hA;
        skip = 1'b1;
      end else begin
        if (!skip) rxb = {lowc < 6'h05, rxb[7:1]};
        if (!skip) rxn++;
        if (rxn == 8) take(rxb);
        if (rxn == 8) rxn = 0;
        skip = 1'b0;
      end
      lowc = 6'h00;
    end else if (!line && prev && txq.size() != 0) begin
      skip = 1'b1;
      if (!txq[0][txn]) hold <= 4'h8;
      txn++;
      if (txn == 8) void'(txq.pop_front());
      if (txn == 8) txn = 0;
    end
    prev = line;
  end
  // falling pulse counts once three samples agree low
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      tdb[i] = {tdb[i][1:0], trig_n[i]};
      if (tdb[i] == 3'h0 && tlvl[i]) begin
        tlvl[i] = 1'b0;
        tcnt[i] = tcnt[i] + 32'h1;
      end else if (tdb[i] == 3'h7) begin
        tlvl[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/test_single_wire_rom_and_transfer_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "swh_defines.svh"
// ==========================================================
// host controller against the device model
module test_single_wire_rom_and_transfer_status;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  swh_pkg::swh_bus_s bus = '0;
  logic [31:0] rdata, d;
  logic busy, dq_o, dq_oe, pull;
  logic [7:0] ta_lo, ta_hi, es;
  logic [7:0] mc[4] = '{8'h0F, 8'hAA, 8'h5A, 8'hA5};
  logic [7:0] hs[2] = '{8'h3C, 8'h69};
  int n_fail = 0, checks = 0, cyc = 0, n = 0;
  int wexp[2] = '{0, 0};
  logic [1:0] trig_n = 2'b11;
  // short line timing so a run stays within a few thousand cycles
  localparam int T_RL = 20, T_PR = 6, T_RR = 15, T_1 = 2, T_0 = 8, T_RD = 7, T_SL = 12;
  // pull-up on the shared line
  wire logic dq_line = ~pull & (dq_oe ? dq_o : 1'b1);
  swh_ctrl #(
    .T_RST_LOW_S(T_RL), .T_PRES_S(T_PR), .T_RST_REC_S(T_RR), .T_W1_S(T_1), .T_W0_S(T_0), .T_RDS_S(T_RD),
    .T_SLOT_S(T_SL),
    .T_RST_LOW_O(T_RL), .T_PRES_O(T_PR), .T_RST_REC_O(T_RR), .T_W1_O(T_1), .T_W0_O(T_0), .T_RDS_O(T_RD),
    .T_SLOT_O(T_SL)
  ) swh_ctrl_i (
    .ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata), .busy(busy),
    .dq_i(dq_line), .dq_o(dq_o), .dq_oe(dq_oe)
  );
  swh_dev_model swh_dev_model_i (.clk(ref_clk), .line(dq_line), .pull(pull), .trig_n(trig_n));
  always #50 ref_clk = ~ref_clk;
  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, tests need about 8000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bw(input logic [2:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= w;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic br(input logic [2:0] a);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
  // line operation, then bounded wait for busy to drop
  task automatic op(input logic [1:0] code, input logic [7:0] b);
    bw(`SWH_A_CTRL, {16'h0000, b, 6'h00, code});
    @(negedge ref_clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk({31'h0, busy}, 32'h0);
  endtask
  task automatic rdb();
    op(2'h3, 8'hFF);
    br(`SWH_A_RX);
  endtask
  task automatic sel(input logic [7:0] c);
    op(2'h1, 8'h00);
    op(2'h2, c);
    if (c == 8'h55 || c == 8'h69) begin
      for (int i = 0; i < 8; i++) op(2'h2, swh_dev_model_i.id[8*i +: 8]);
    end
  endtask
  task automatic rd_sp(input logic [7:0] e);
    sel(8'hCC);
    op(2'h2, 8'hAA);
    rdb();
    chk(d & 32'hFF, {24'h0, ta_lo});
    rdb();
    chk(d & 32'hFF, {24'h0, ta_hi});
    rdb();
    chk(d & 32'hFF, {24'h0, e});
    br(`SWH_A_ADDR);
    chk(d, {8'h00, e, ta_hi, ta_lo});
  endtask
  initial begin
    d = $urandom(77);
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    br(`SWH_A_STAT);
    chk(d, 32'h10);
    chk(swh_dev_model_i.tcnt[0], 32'h0);
    br(3'h7);
    chk(d, 32'h0);
    // memory commands straight after a reset pulse are turned away
    foreach (mc[i]) begin
      op(2'h1, 8'h00);
      br(`SWH_A_STAT);
      chk(d & 32'h22, 32'h02);
      op(2'h2, mc[i]);
      br(`SWH_A_STAT);
      chk(d & 32'h24, 32'h20);
      bw(`SWH_A_CFG, 32'h4);
    end
    op(2'h1, 8'h00);
    op(2'h2, 8'h33);
    bw(`SWH_A_CFG, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rdb();
      chk(d & 32'hFF, {24'h0, swh_dev_model_i.id[8*i +: 8]});
    end
    br(`SWH_A_STAT);
    chk(d & 32'hFF3C, 32'h0014);
    // offset at 1CH fills after four bytes; a random offset takes one
    for (int k = 0; k < 2; k++) begin
      n = k ? 4 : 1;
      ta_lo = {k ? {2'b10, 1'($urandom)} : 3'($urandom), k ? 5'h1C : 5'($urandom)};
      ta_hi = {7'h00, k ? 1'b1 : 1'($urandom)};
      sel(k ? 8'hCC : 8'h55);
      op(2'h2, 8'h0F);
      op(2'h2, ta_lo);
      op(2'h2, ta_hi);
      for (int i = 0; i < n; i++) op(2'h2, 8'($urandom));
      es = {3'b000, ta_lo[4:0] + 5'(n - 1)};
      rd_sp(es);
      br(`SWH_A_STAT);
      chk(d & 32'h40, {25'h0, ta_lo[4:0] != 5'h00, 6'h00});
      sel(8'hCC);
      op(2'h2, 8'h5A);
      op(2'h2, ta_lo);
      op(2'h2, ta_hi);
      op(2'h2, es);
      rd_sp(es | 8'h80);
      if (ta_hi[0] && ta_lo[7:6] == 2'b10) wexp[ta_lo[5]]++;
    end
    foreach (hs[i]) begin
      sel(hs[i]);
      br(`SWH_A_STAT);
      chk(d & 32'h0C, 32'h0C);
      op(2'h1, 8'h00);
      br(`SWH_A_STAT);
      chk(d & 32'h0A, 32'h0A);
      bw(`SWH_A_CFG, 32'h2);
      br(`SWH_A_STAT);
      chk(d & 32'h08, 32'h00);
    end
    // a one-cycle glitch is ignored, three longer pulses count
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      trig_n <= 2'b00;
      repeat (i == 0 ? 1 : 4) @(posedge ref_clk);
      trig_n <= 2'b11;
      repeat (4) @(posedge ref_clk);
    end
    chk(swh_dev_model_i.tcnt[0], 32'h3);
    chk(swh_dev_model_i.tcnt[1], 32'h3);
    chk(swh_dev_model_i.wcnt[0], 32'(wexp[0]));
    chk(swh_dev_model_i.wcnt[1], 32'(wexp[1]));
    complete_run();
  end
endmodule
`default_nettype wire
